// ===== core/cawo_pkg.sv
package cawo_pkg;

	// Register space
	localparam logic [7:0] PAGE_MAIN        = 8'h00;
	localparam logic [7:0] ADDR_CONTROL     = 8'hd8;
	localparam logic [7:0] ADDR_COUNTER_MODE = 8'hd9;
	localparam logic [7:0] ADDR_PWM_CONFIG  = 8'hdf;
	localparam logic [7:0] ADDR_COUNT_LOW   = 8'hf9;
	localparam logic [7:0] ADDR_COUNT_HIGH  = 8'hfa;
	localparam logic [7:0] ADDR_MODE_BASE   = 8'ha0;
	localparam logic [7:0] ADDR_LOW_BASE    = 8'ha8;
	localparam logic [7:0] ADDR_HIGH_BASE   = 8'hb0;
	localparam int         NUM_MODULES      = 6;

	// Control register fields
	localparam int BIT_COUNTER_OVF  = 7;
	localparam int BIT_COUNTER_RUN  = 6;
	localparam int BIT_EVENT_TOP    = 5;

	// Module mode register fields
	localparam int BIT_CMP_ENABLE   = 6;
	localparam int BIT_EQUAL_ENABLE = 3;
	localparam int BIT_SQUARE_WAVE  = 2;
	localparam int BIT_PWM_ENABLE   = 1;
	localparam int BIT_EVENT_INT_EN = 0;

	// Counter mode register fields
	localparam int BIT_CPS_LOW      = 1;
	localparam int BIT_CPS_HIGH     = 3;
	localparam int BIT_OVF_INT_EN   = 0;

	// Pwm config register fields
	localparam int BIT_CYCLE_OVF    = 5;
	localparam int BIT_CYCLE_LENGTH_SELECT_LOW    = 0;
	localparam int BIT_CYCLE_LENGTH_SELECT_HIGH   = 1;
	localparam logic [1:0] CYCLE_LENGTH_SELECT_8BIT = 2'h0;
	localparam int BASE_CYCLE_BITS  = 8;

	// Reset values and compare constants
	localparam logic [7:0] RESET_BYTE  = 8'h00;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [7:0] BYTE_ZERO   = 8'h00;
	localparam logic [15:0] WORD_MAX   = 16'hffff;

	// Clock source codes
	localparam logic [2:0] CPS_DIV12 = 3'h0;
	localparam logic [2:0] CPS_DIV4  = 3'h1;
	localparam logic [2:0] CPS_TIMER = 3'h2;
	localparam logic [2:0] CPS_EXT   = 3'h3;
	localparam logic [3:0] DIV12_LAST = 4'hb;
	localparam logic [3:0] DIV4_LAST  = 4'h3;

	typedef enum {
		CAWO_IDLE,
		CAWO_FREQ,
		CAWO_PWM8,
		CAWO_OTHER
	} cawo_mode_type;

endpackage

// ===== core/cawo_channel.sv
`timescale 1ns/1ps
module cawo_channel (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        srst,
	// Counter timing
	input  wire logic        step,
	input  wire logic [15:0] count,
	input  wire logic [1:0]  cycleSelect,
	// Software writes
	input  wire logic        writeMode,
	input  wire logic        writeLow,
	input  wire logic        writeHigh,
	input  wire logic [7:0]  writeData,
	// State
	output logic      [7:0]  modeReg,
	output logic      [7:0]  compareLow,
	output logic      [7:0]  compareHigh,
	output logic             modulePin,
	output logic             matchEvent
);

	cawo_pkg::cawo_mode_type mode;

	wire cmpEnable = modeReg[cawo_pkg::BIT_CMP_ENABLE];
	wire equalEnable = modeReg[cawo_pkg::BIT_EQUAL_ENABLE];
	wire squareWave = modeReg[cawo_pkg::BIT_SQUARE_WAVE];
	wire pwmEnable = modeReg[cawo_pkg::BIT_PWM_ENABLE];
	wire lowWrap = (count[7:0] == cawo_pkg::BYTE_ZERO);
	// At the wrap the reloaded value is compared, so a high byte of zero gives full duty
	wire [7:0] pwmTarget = lowWrap ? compareHigh : compareLow;
	wire pwmMatch = cmpEnable && (count[7:0] == pwmTarget);
	wire freqMatch = (count[7:0] == compareLow);
	wire fullMatch = (count == {compareHigh, compareLow});
	// Adding a zero high byte leaves the low byte, i.e. 256 counter steps per half period
	wire [7:0] freqNextLow = 8'(compareLow + compareHigh);

	always_comb begin
		if (cmpEnable && squareWave && pwmEnable) begin
			mode = cawo_pkg::CAWO_FREQ;
		end else if (cmpEnable && pwmEnable && !squareWave && cycleSelect == cawo_pkg::CYCLE_LENGTH_SELECT_8BIT) begin
			mode = cawo_pkg::CAWO_PWM8;
		end else if (pwmEnable && !squareWave) begin
			mode = cawo_pkg::CAWO_PWM8;
		end else begin
			mode = cawo_pkg::CAWO_OTHER;
		end
	end

	wire pwm8Active = (mode == cawo_pkg::CAWO_PWM8) && (cycleSelect == cawo_pkg::CYCLE_LENGTH_SELECT_8BIT);
	wire freqActive = (mode == cawo_pkg::CAWO_FREQ);

	wire freqStep = step && freqActive && freqMatch;
	wire pwmStep = step && pwm8Active;

	logic [7:0] next_low;
	logic [7:0] next_mode;
	logic       next_pin;
	logic       next_event;

	always_comb begin
		next_low = compareLow;
		next_mode = modeReg;
		next_pin = modulePin;
		next_event = 1'b0;
		if (freqStep) begin
			next_pin = !modulePin;
			next_low = freqNextLow;
		end
		if (step && freqActive && equalEnable && fullMatch) begin
			next_event = 1'b1;
		end
		if (pwmStep) begin
			if (lowWrap) begin
				next_low = compareHigh;
				next_pin = pwmMatch;
			end else if (pwmMatch) begin
				next_pin = 1'b1;
			end
			next_event = pwmMatch && equalEnable;
		end
		if (writeMode) begin
			next_mode = writeData;
		end
		if (writeLow) begin
			next_low = writeData;
			next_mode[cawo_pkg::BIT_CMP_ENABLE] = 1'b0;
		end
		if (writeHigh) begin
			next_mode[cawo_pkg::BIT_CMP_ENABLE] = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			modeReg <= cawo_pkg::RESET_BYTE;
			compareLow <= cawo_pkg::RESET_BYTE;
			compareHigh <= cawo_pkg::RESET_BYTE;
			modulePin <= 1'b0;
			matchEvent <= 1'b0;
		end else begin
			modeReg <= next_mode;
			compareLow <= next_low;
			compareHigh <= writeHigh ? writeData : compareHigh;
			modulePin <= next_pin;
			matchEvent <= next_event;
		end
	end

endmodule

// ===== core/cawo_wave_output.sv
`timescale 1ns/1ps
module cawo_wave_output #(
	parameter int NUM_MODULES = cawo_pkg::NUM_MODULES
) (
	// Clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   srst,
	// Register port
	input  wire logic [7:0]             register_page_select,
	input  wire logic [7:0]             sfrAddr,
	input  wire logic                   sfrWrite,
	input  wire logic                   sfrRead,
	input  wire logic [7:0]             sfrWrData,
	output logic      [7:0]             sfrRdData,
	// Single-bit access
	input  wire logic                   bitWrite,
	input  wire logic [2:0]             bitIndex,
	input  wire logic                   bitValue,
	// Clock source ticks
	input  wire logic                   timerTick,
	input  wire logic                   extTick,
	// Outputs
	output logic      [NUM_MODULES-1:0] modulePins,
	output logic                        irqRequest
);

	////////////////////////////////////////////////////////////////////////////
	// Address decode

	wire pageHit = (register_page_select == cawo_pkg::PAGE_MAIN);
	wire hitControl = pageHit && (sfrAddr == cawo_pkg::ADDR_CONTROL);
	wire hitCounterMode = pageHit && (sfrAddr == cawo_pkg::ADDR_COUNTER_MODE);
	wire hitPwmConfig = pageHit && (sfrAddr == cawo_pkg::ADDR_PWM_CONFIG);
	wire hitCountLow = pageHit && (sfrAddr == cawo_pkg::ADDR_COUNT_LOW);
	wire hitCountHigh = pageHit && (sfrAddr == cawo_pkg::ADDR_COUNT_HIGH);
	// Anything else on the page besides these five and the module registers ignores writes and reads as zero
	wire wrControl = sfrWrite && hitControl;
	wire bitControl = bitWrite && hitControl;
	wire wrCounterMode = sfrWrite && hitCounterMode;
	wire wrPwmConfig = sfrWrite && hitPwmConfig;
	wire wrCountLow = sfrWrite && hitCountLow;
	wire wrCountHigh = sfrWrite && hitCountHigh;

	logic [7:0]             control;
	logic [7:0]             counterMode;
	logic [7:0]             pwmConfig;
	logic [15:0]            count;
	logic                   step;
	logic [3:0]             prescale;

	////////////////////////////////////////////////////////////////////////////
	// Counter clock source

	wire [2:0] clockSource = counterMode[cawo_pkg::BIT_CPS_HIGH:cawo_pkg::BIT_CPS_LOW];
	wire [3:0] prescaleLast = (clockSource == cawo_pkg::CPS_DIV12) ? cawo_pkg::DIV12_LAST : cawo_pkg::DIV4_LAST;
	wire prescaleWrap = (prescale >= prescaleLast);
	logic sourceTick;

	always_comb begin
		case (clockSource)
			cawo_pkg::CPS_DIV12: sourceTick = prescaleWrap;
			cawo_pkg::CPS_DIV4:  sourceTick = prescaleWrap;
			cawo_pkg::CPS_TIMER: sourceTick = timerTick;
			cawo_pkg::CPS_EXT:   sourceTick = extTick;
			default:             sourceTick = 1'b1;
		endcase
	end

	wire counterRun = control[cawo_pkg::BIT_COUNTER_RUN];
	wire advance = counterRun && sourceTick;
	// Software writes to the count take priority over advancing
	wire countWritten = wrCountLow || wrCountHigh;
	wire counterWrap = advance && !countWritten && (count == cawo_pkg::WORD_MAX);

	// Free-running divider; a source change mid-count only shortens one period
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prescale <= 4'h0;
		end else begin
			prescale <= prescaleWrap ? 4'h0 : 4'(prescale + 4'h1);
		end
	end

	logic [15:0] next_count;

	always_comb begin
		next_count = count;
		if (wrCountLow) begin
			next_count[7:0] = sfrWrData;
		end else if (wrCountHigh) begin
			next_count[15:8] = sfrWrData;
		end else if (advance) begin
			next_count = 16'(count + 16'h0001);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			count <= cawo_pkg::RESET_WORD;
		end else begin
			count <= next_count;
		end
	end

	// Channels compare the count one edge after it moves, so step lags by one
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			step <= 1'b0;
		end else begin
			step <= advance && !countWritten;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Modules

	wire [1:0] cycleSelect = pwmConfig[cawo_pkg::BIT_CYCLE_LENGTH_SELECT_HIGH:cawo_pkg::BIT_CYCLE_LENGTH_SELECT_LOW];
	wire [7:0] moduleMode [NUM_MODULES];
	wire [7:0] moduleLow [NUM_MODULES];
	wire [7:0] moduleHigh [NUM_MODULES];
	wire [NUM_MODULES-1:0] matchEvents;
	wire [NUM_MODULES-1:0] eventIntEnable;

	genvar g;
	generate
		for (g = 0; g < NUM_MODULES; g = g + 1) begin : gen_module
			wire wrMode = sfrWrite && pageHit && sfrAddr == 8'(cawo_pkg::ADDR_MODE_BASE + g);
			wire wrLow = sfrWrite && pageHit && sfrAddr == 8'(cawo_pkg::ADDR_LOW_BASE + g);
			wire wrHigh = sfrWrite && pageHit && sfrAddr == 8'(cawo_pkg::ADDR_HIGH_BASE + g);
			cawo_channel u_channel (
				.sys_clk     (sys_clk),
				.srst        (srst),
				.step        (step),
				.count       (count),
				.cycleSelect (cycleSelect),
				.writeMode   (wrMode),
				.writeLow    (wrLow),
				.writeHigh   (wrHigh),
				.writeData   (sfrWrData),
				.modeReg     (moduleMode[g]),
				.compareLow  (moduleLow[g]),
				.compareHigh (moduleHigh[g]),
				.modulePin   (modulePins[g]),
				.matchEvent  (matchEvents[g])
			);
			assign eventIntEnable[g] = moduleMode[g][cawo_pkg::BIT_EVENT_INT_EN];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Shared cycle overflow

	// Cycle length is 8 plus the select field; pwm modules only run at the 8-bit length
	wire [4:0] cycleBits = 5'(cawo_pkg::BASE_CYCLE_BITS) + 5'(cycleSelect);
	wire [16:0] cycleSpan = 17'h1 << cycleBits;
	wire [15:0] cycleMask = 16'(cycleSpan - 17'h1);
	wire [15:0] cycleCount = count & cycleMask;
	wire cycleWrap = step && (cycleCount == cawo_pkg::RESET_WORD);

	////////////////////////////////////////////////////////////////////////////
	// Control register and flags

	logic [7:0] controlSoft;
	logic [7:0] hwSet;
	logic [7:0] next_control;
	logic [7:0] next_pwmConfig;

	always_comb begin
		controlSoft = control;
		if (wrControl) begin
			controlSoft = sfrWrData;
		end
		if (bitControl) begin
			controlSoft[bitIndex] = bitValue;
		end
		hwSet = cawo_pkg::RESET_BYTE;
		hwSet[cawo_pkg::BIT_COUNTER_OVF] = counterWrap;
		hwSet[cawo_pkg::BIT_EVENT_TOP:0] = 6'(matchEvents);
		// Hardware sets merge last, so a clear in the same cycle loses
		next_control = controlSoft | hwSet;
	end

	always_comb begin
		next_pwmConfig = pwmConfig;
		if (wrPwmConfig) begin
			next_pwmConfig = sfrWrData;
		end
		if (cycleWrap) begin
			next_pwmConfig[cawo_pkg::BIT_CYCLE_OVF] = 1'b1;
		end
	end

	wire [7:0] next_counterMode = wrCounterMode ? sfrWrData : counterMode;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			control <= cawo_pkg::RESET_BYTE;
		end else begin
			control <= next_control;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			counterMode <= cawo_pkg::RESET_BYTE;
		end else begin
			counterMode <= next_counterMode;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pwmConfig <= cawo_pkg::RESET_BYTE;
		end else begin
			pwmConfig <= next_pwmConfig;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt request

	wire overflowIrq = control[cawo_pkg::BIT_COUNTER_OVF] && counterMode[cawo_pkg::BIT_OVF_INT_EN];
	wire [NUM_MODULES-1:0] eventFlags = control[NUM_MODULES-1:0];
	wire [NUM_MODULES-1:0] eventRequests = eventFlags & eventIntEnable;
	wire eventIrq = |eventRequests;
	// One shared request line; software polls the flags to find the source
	wire next_irq = overflowIrq || eventIrq;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			irqRequest <= 1'b0;
		end else begin
			irqRequest <= next_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read back

	// Unmapped addresses read as zero
	logic [7:0] readMux;

	always_comb begin
		readMux = cawo_pkg::RESET_BYTE;
		if (pageHit) begin
			case (sfrAddr)
				cawo_pkg::ADDR_CONTROL:      readMux = control;
				cawo_pkg::ADDR_COUNTER_MODE: readMux = counterMode;
				cawo_pkg::ADDR_PWM_CONFIG:   readMux = pwmConfig;
				cawo_pkg::ADDR_COUNT_LOW:    readMux = count[7:0];
				cawo_pkg::ADDR_COUNT_HIGH:   readMux = count[15:8];
				default:                     readMux = cawo_pkg::RESET_BYTE;
			endcase
			for (int i = 0; i < NUM_MODULES; i++) begin
				if (sfrAddr == 8'(cawo_pkg::ADDR_MODE_BASE + i)) begin
					readMux = moduleMode[i];
				end
				if (sfrAddr == 8'(cawo_pkg::ADDR_LOW_BASE + i)) begin
					readMux = moduleLow[i];
				end
				if (sfrAddr == 8'(cawo_pkg::ADDR_HIGH_BASE + i)) begin
					readMux = moduleHigh[i];
				end
			end
		end
	end

	// Registered so the read data is stable for the whole next cycle
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sfrRdData <= cawo_pkg::RESET_BYTE;
		end else if (sfrRead) begin
			sfrRdData <= readMux;
		end
	end

endmodule

// ===== verification/cawo_wave_output_properties.sv
`timescale 1ns/1ps
module cawo_wave_output_checker #(
	parameter int NUM_MODULES = 6
) (
	// Clock and reset
	input wire logic                   sys_clk,
	input wire logic                   srst,
	// Register port
	input wire logic [7:0]             register_page_select,
	input wire logic [7:0]             sfrAddr,
	input wire logic                   sfrWrite,
	input wire logic                   sfrRead,
	input wire logic [7:0]             sfrWrData,
	input wire logic [7:0]             sfrRdData,
	// Single-bit access
	input wire logic                   bitWrite,
	input wire logic [2:0]             bitIndex,
	input wire logic                   bitValue,
	// Ticks and outputs
	input wire logic                   timerTick,
	input wire logic                   extTick,
	input wire logic [NUM_MODULES-1:0] modulePins,
	input wire logic                   irqRequest
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	logic runShadow;
	wire  pg0    = register_page_select == 8'h00;
	wire  anyWr  = sfrWrite | bitWrite;
	wire  ctlRd  = sfrRead & pg0 & sfrAddr == 8'hd8 & !anyWr;
	wire  cntRd  = sfrRead & pg0 & sfrAddr == 8'hf9 & !anyWr & !runShadow;
	wire  runWr  = bitWrite & pg0 & sfrAddr == 8'hd8 & bitIndex == 3'h6;
	wire  lowWr  = sfrWrite & pg0 & sfrAddr >= 8'ha8 & int'(sfrAddr - 8'ha8) < NUM_MODULES;
	wire  highWr = sfrWrite & pg0 & sfrAddr >= 8'hb0 & int'(sfrAddr - 8'hb0) < NUM_MODULES;
	wire  modeRd = sfrRead & pg0 & !anyWr;
	// Hardware never touches the run bit, so software writes alone track it
	always_ff @(posedge sys_clk) begin
		if (srst)
			runShadow <= 1'b0;
		else if (sfrWrite & pg0 & sfrAddr == 8'hd8)
			runShadow <= sfrWrData[6];
		else if (runWr)
			runShadow <= bitValue;
	end
	////////////////////////////////////////////////////////////////////////////////
	rd_foreign_a: assert property (sfrRead && !pg0 |=> sfrRdData == 8'h00)
		else $error("Read off page zero returned data");
	rd_hold_a: assert property (!sfrRead |=> $stable(sfrRdData))
		else $error("Read data moved without a read");
	run_bit_a: assert property (ctlRd |=> sfrRdData[6] == $past(runShadow))
		else $error("Run bit does not read back as written");
	flag_sticky_a: assert property (ctlRd ##1 !anyWr ##1 ctlRd |=> ($past(sfrRdData) & ~sfrRdData) == 8'h00)
		else $error("Control bit dropped without software");
	low_clears_a: assert property (lowWr ##1 !anyWr ##1 (modeRd && sfrAddr == $past(sfrAddr, 2) - 8'h08) |=> !sfrRdData[6])
		else $error("Compare low write left comparator enabled");
	high_sets_a: assert property (highWr ##1 !anyWr ##1 (modeRd && sfrAddr == $past(sfrAddr, 2) - 8'h10) |=> sfrRdData[6])
		else $error("Compare high write left comparator disabled");
	count_hold_a: assert property (cntRd ##1 (!anyWr && !runShadow) ##1 cntRd |=> $stable(sfrRdData))
		else $error("Counter moved while stopped");
	reset_state_a: assert property ($fell(srst) |-> modulePins == '0 && !irqRequest && sfrRdData == 8'h00)
		else $error("Outputs not cleared by reset");
endmodule

bind cawo_wave_output cawo_wave_output_checker #(.NUM_MODULES(NUM_MODULES)) chk_u (.sys_clk(sys_clk), .srst(srst),
	.register_page_select(register_page_select), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWrData(sfrWrData),
	.sfrRdData(sfrRdData), .bitWrite(bitWrite), .bitIndex(bitIndex), .bitValue(bitValue), .timerTick(timerTick),
	.extTick(extTick), .modulePins(modulePins), .irqRequest(irqRequest));

// ===== verification/test_counter_array_wave_output.sv
`timescale 1ns/1ps
module test_counter_array_wave_output;
	logic        sys_clk, srst, sfrWrite, sfrRead, bitWrite, bitValue, timerTick, extTick, irqRequest;
	logic [7:0]  register_page_select, sfrAddr, sfrWrData, sfrRdData, rv;
	logic [2:0]  bitIndex;
	logic [5:0]  modulePins;
	int          err_count, n_checks, cycles, h1, h2;
	// Address and value expected after reset; 0xa6 is past the last module
	logic [15:0] rows [10] = '{16'hd800, 16'hd900, 16'hdf00, 16'ha000, 16'ha500,
		16'ha600, 16'ha800, 16'hb500, 16'hf900, 16'hfa00};
	// Square wave on 0, pwm with event flag on 1, pwm without comparator on 2
	logic [15:0] cfg [7] = '{16'ha046, 16'ha940, 16'hb140, 16'ha14a, 16'hb280, 16'ha202, 16'hd908};

	cawo_wave_output #(.NUM_MODULES(6)) dut_u (.sys_clk(sys_clk), .srst(srst), .register_page_select(register_page_select),
		.sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWrData(sfrWrData),
		.sfrRdData(sfrRdData), .bitWrite(bitWrite), .bitIndex(bitIndex), .bitValue(bitValue),
		.timerTick(timerTick), .extTick(extTick), .modulePins(modulePins), .irqRequest(irqRequest));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Whole run needs about 700 cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 8000) begin
			err_count++;
			results;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task tick;
		@(posedge sys_clk) #1;
	endtask

	task chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH at %0t got %h expected %h", $time, g, e);
		end
	endtask

	// Idle edge after each access keeps strobes from being set twice in one step
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		sfrAddr = a;
		sfrWrData = d;
		sfrWrite = w;
		sfrRead = !w;
		tick;
		sfrWrite = 1'b0;
		sfrRead = 1'b0;
		rv = sfrRdData;
		tick;
	endtask

	task bw(input logic [2:0] i, input logic v);
		sfrAddr = 8'hd8;
		bitIndex = i;
		bitValue = v;
		bitWrite = 1'b1;
		tick;
		bitWrite = 1'b0;
		tick;
	endtask

	// Cycles between two pin changes, after the next change seen
	task gap(input int i, output int g);
		logic p;
		p = modulePins[i];
		g = 0;
		while (modulePins[i] === p && g < 600) begin
			tick;
			g++;
		end
		p = modulePins[i];
		g = 0;
		while (modulePins[i] === p && g < 600) begin
			tick;
			g++;
		end
	endtask

	task results;
		$display("Checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		srst = 1'b1;
		{sfrWrite, sfrRead, bitWrite, bitValue, timerTick, extTick} = 6'h00;
		{register_page_select, sfrAddr, sfrWrData} = 24'h000000;
		bitIndex = 3'h0;
		repeat (3) tick;
		srst = 1'b0;
		tick;
		foreach (rows[k]) begin
			acc(1'b0, rows[k][15:8], 8'h00);
			chk(rv, rows[k][7:0]);
		end
		acc(1'b1, 8'ha0, 8'h40);
		acc(1'b1, 8'ha8, 8'h10);
		acc(1'b0, 8'ha0, 8'h00);
		chk(rv, 8'h00);
		acc(1'b1, 8'hb0, 8'h05);
		acc(1'b0, 8'ha0, 8'h00);
		chk(rv, 8'h40);
		foreach (cfg[k])
			acc(1'b1, cfg[k][15:8], cfg[k][7:0]);
		bw(3'h6, 1'b1);
		gap(0, h1);
		chk(h1[15:0], 16'h0005);
		acc(1'b1, 8'hb0, 8'h00);
		gap(0, h1);
		chk(h1[15:0], 16'h0100);
		h1 = 0;
		h2 = 0;
		repeat (256) begin
			tick;
			h1 += int'(modulePins[1] === 1'b1);
			h2 += int'(modulePins[2] === 1'b1);
		end
		chk(h1[15:0], 16'h00c0);
		chk(h2[15:0], 16'h0000);
		acc(1'b0, 8'hdf, 8'h00);
		chk(rv & 8'h20, 8'h20);
		repeat (2) begin
			acc(1'b0, 8'hd8, 8'h00);
			chk(rv, 8'h42);
		end
		register_page_select = 8'h01;
		acc(1'b0, 8'hd8, 8'h00);
		register_page_select = 8'h00;
		chk(rv, 8'h00);
		acc(1'b1, 8'hfa, 8'hff);
		acc(1'b1, 8'hf9, 8'hf0);
		repeat (20) tick;
		acc(1'b1, 8'hd9, 8'h09);
		repeat (3) tick;
		chk(irqRequest, 1'b1);
		bw(3'h7, 1'b0);
		repeat (3) tick;
		chk(irqRequest, 1'b0);
		acc(1'b1, 8'ha1, 8'h4b);
		tick;
		chk(irqRequest, 1'b1);
		bw(3'h6, 1'b0);
		acc(1'b0, 8'hf9, 8'h00);
		h1 = int'(rv);
		acc(1'b0, 8'hf9, 8'h00);
		chk(rv, h1[15:0]);
		for (int k = 2; k < 4; k++) begin
			acc(1'b1, 8'hd9, 8'(k << 1));
			acc(1'b1, 8'hf9, 8'h00);
			bw(3'h6, 1'b1);
			repeat (10) begin
				timerTick = (k == 2);
				extTick = (k == 3);
				tick;
				timerTick = 1'b0;
				extTick = 1'b0;
				tick;
			end
			bw(3'h6, 1'b0);
			acc(1'b0, 8'hf9, 8'h00);
			chk(rv, 16'h000a);
		end
		srst = 1'b1;
		repeat (2) tick;
		srst = 1'b0;
		tick;
		chk(modulePins, 6'h00);
		acc(1'b0, 8'hd8, 8'h00);
		chk(rv, 8'h00);
		results;
	end
endmodule
